// >>> hbridge_pkg.sv
// constants and types for the h-bridge pwm output steering block
package hbridge_pkg;

   // ************************************************************
   // bus and counter widths
   // ************************************************************
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 16;
   localparam int CNT_W     = 11;
   localparam int NUM_PAIRS = 4;

   // ************************************************************
   // register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] OFS_CONTROL  = 8'h00;   // fast mode, select_a
   localparam logic [7:0] OFS_PERIOD   = 8'h04;   // period_reg
   localparam logic [7:0] OFS_COUNTER  = 8'h08;   // timer counter, read only
   localparam logic [2:0] PAGE_CTRL    = 3'h1;    // channel_ctrl_reg at 0x20 + 4*ch
   localparam logic [2:0] PAGE_DUTY    = 3'h2;    // duty_reg at 0x40 + 4*ch

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int CTL_FAST_BIT   = 0;
   localparam int CTL_SELA_BIT   = 1;
   localparam int CH_ALIGN_LSB   = 0;   // align_mode [1:0]
   localparam int CH_OMODE_LSB   = 2;   // output_mode [3:2]
   localparam int CH_DUAL_BIT    = 8;   // read only: pair runs dual full
   localparam int DUTY_SIGN_BIT  = 15;
   localparam int FAST_DUTY_LSB  = 8;   // high byte carries D[8:2]

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [CNT_W-1:0] PERIOD_RST = 11'h000;
   localparam logic [CNT_W-1:0] DUTY_RST   = 11'h000;

   // ************************************************************
   // encodings and carriers
   // ************************************************************
   typedef enum logic [1:0]
   {
      ALIGN_OFF    = 2'h0,
      ALIGN_LEFT   = 2'h1,
      ALIGN_RIGHT  = 2'h2,
      ALIGN_CENTER = 2'h3
   } align_t;

   typedef enum logic [1:0]
   {
      OM_HALF_M = 2'h0,
      OM_HALF_P = 2'h1,
      OM_FULL   = 2'h2,
      OM_DUAL   = 2'h3
   } omode_t;

   typedef struct packed
   {
      omode_t outputMode;
      align_t alignMode;
   } chan_cfg_t;

   typedef struct packed
   {
      logic oe;      // high while the block drives the pin
      logic level;
   } pin_t;

endpackage

// >>> hbridge_pwm_output_steering.sv
// h-bridge pwm channel pairs: counter, duty buffering, alignment and pin steering
//
// Contract
// - dual full needs both enabled, both 11
// - lone dual request acts as full mode
// - align_mode 00 disables, else enabled
// - sel 0 sign 0: pwm low on M
// - sel 0 sign 1: pwm low on P
// - sel 1 sign 0: pwm high on P
// - sel 1 sign 1: pwm high on M
// - half mode: one pin pwm, sign ignored
// - released pins are not driven
// - full mode reloads working duty each overflow
// - dual copies pair at next overflow
// - duty from D[10:0], or D[8:2] fast
// - fast: high byte write is complete update
// - left: start active, inactive at duty
// - right: active after period minus duty
// - center: even left, odd right, start even
// - center without disable may start odd
// - dual copy only after odd written
// - reload when period zero or disabled
// - after reset channels disabled, pins released
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ns
module hbridge_pwm_output_steering
#(
   parameter int NP = hbridge_pkg::NUM_PAIRS
)
(
   // clock and reset
   input  wire logic                            core_clk,
   input  wire logic                            rstn,
   // register port
   input  wire logic [hbridge_pkg::ADDR_W-1:0]  regAddr,
   input  wire logic [hbridge_pkg::DATA_W-1:0]  regWrData,
   input  wire logic [1:0]                      regWrBytes,
   input  wire logic                            regWr,
   input  wire logic                            regRd,
   output logic      [hbridge_pkg::DATA_W-1:0]  regRdData,
   // pins of each channel pair
   output hbridge_pkg::pin_t [NP-1:0]           evenPlusPin,
   output hbridge_pkg::pin_t [NP-1:0]           evenMinusPin,
   output hbridge_pkg::pin_t [NP-1:0]           oddPlusPin,
   output hbridge_pkg::pin_t [NP-1:0]           oddMinusPin
);
   import hbridge_pkg::*;

   localparam int NCH = 2 * NP;

   // ************************************************************
   // reset synchroniser
   // ************************************************************
   logic rstMetaN_q;
   logic rstSyncN_q;

   // release through two flops
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rstMetaN_q <= 1'b0;
         rstSyncN_q <= 1'b0;
      end
      else
      begin
         rstMetaN_q <= 1'b1;
         rstSyncN_q <= rstMetaN_q;
      end
   end

   // ************************************************************
   // address decode
   // ************************************************************
   wire       [2:0] chSel    = regAddr[4:2];
   wire       [2:0] page     = regAddr[7:5];
   wire             hitCtl   = (regAddr == OFS_CONTROL);
   wire             hitPer   = (regAddr == OFS_PERIOD);
   wire             hitCnt   = (regAddr == OFS_COUNTER);
   wire             hitChCfg = (page == PAGE_CTRL) && ({1'b0, chSel} < 4'(NCH))
                               && (regAddr[1:0] == 2'h0);
   wire             hitDuty  = (page == PAGE_DUTY) && ({1'b0, chSel} < 4'(NCH))
                               && (regAddr[1:0] == 2'h0);
   wire             hiByte   = regWrBytes[1];
   wire             loByte   = regWrBytes[0];

   // ************************************************************
   // global control and period
   // ************************************************************
   logic             fast_q;
   logic             selectA_q;
   logic [CNT_W-1:0] period_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;

   // control and period registers
   always_ff @(posedge core_clk or negedge rstSyncN_q)
   begin
      if (!rstSyncN_q)
      begin
         fast_q    <= 1'b0;
         selectA_q <= 1'b0;
         period_q  <= PERIOD_RST;
      end
      else if (regWr && hitCtl && loByte)
      begin
         fast_q    <= regWrData[CTL_FAST_BIT];
         selectA_q <= regWrData[CTL_SELA_BIT];
      end
      else if (regWr && hitPer)
      begin
         if (loByte)
            period_q[7:0] <= regWrData[7:0];
         if (hiByte)
            period_q[CNT_W-1:8] <= regWrData[CNT_W-1:8];
      end
   end

   // ************************************************************
   // shared timer counter
   // ************************************************************
   wire periodZero = (period_q == PERIOD_RST);
   wire overflow   = !periodZero && (cnt_q >= period_q - 11'h001);

   assign cnt_d = (periodZero || overflow) ? 11'h000 : cnt_q + 11'h001;

   // counter register
   always_ff @(posedge core_clk or negedge rstSyncN_q)
   begin
      if (!rstSyncN_q)
         cnt_q <= 11'h000;
      else
         cnt_q <= cnt_d;
   end

   // ************************************************************
   // channel configuration and duty bus registers
   // ************************************************************
   chan_cfg_t        cfg_q     [NCH];
   logic [CNT_W-1:0] duty_q    [NCH];
   logic             sign_q    [NCH];
   logic [CNT_W-1:0] workDuty_q[NCH];
   logic             workSign_q[NCH];
   logic [NCH-1:0]   enabled;
   logic [NCH-1:0]   dualMode;
   logic [NCH-1:0]   load;
   logic [NP-1:0]    oddWritten_q;
   wire              dutyWr    = regWr && hitDuty;

   // bus-side registers, one writer for all channels
   always_ff @(posedge core_clk or negedge rstSyncN_q)
   begin
      if (!rstSyncN_q)
      begin
         for (int i = 0; i < NCH; i++)
         begin
            cfg_q[i]  <= '{outputMode: OM_HALF_M, alignMode: ALIGN_OFF};
            duty_q[i] <= DUTY_RST;
            sign_q[i] <= 1'b0;
         end
      end
      else if (regWr && hitChCfg && loByte)
      begin
         cfg_q[chSel] <= chan_cfg_t'(regWrData[3:0]);
      end
      else if (dutyWr && fast_q)
      begin
         if (hiByte)
         begin
            duty_q[chSel] <= {2'b00, regWrData[FAST_DUTY_LSB +: 7], 2'b00};
            sign_q[chSel] <= regWrData[DUTY_SIGN_BIT];
         end
      end
      else if (dutyWr)
      begin
         if (loByte)
            duty_q[chSel][7:0] <= regWrData[7:0];
         if (hiByte)
         begin
            duty_q[chSel][CNT_W-1:8] <= regWrData[CNT_W-1:8];
            sign_q[chSel]            <= regWrData[DUTY_SIGN_BIT];
         end
      end
   end

   // ************************************************************
   // dual mode odd-write tracking per pair
   // ************************************************************
   // set on odd duty write while dual; a write beats the clearing copy
   always_ff @(posedge core_clk or negedge rstSyncN_q)
   begin
      if (!rstSyncN_q)
         oddWritten_q <= '0;
      else
      begin
         for (int p = 0; p < NP; p++)
         begin
            if (dutyWr && (chSel == 3'(2 * p + 1)) && dualMode[2 * p])
               oddWritten_q[p] <= 1'b1;
            else if (!dualMode[2 * p] || (overflow && oddWritten_q[p]))
               oddWritten_q[p] <= 1'b0;
         end
      end
   end

   // ************************************************************
   // per-channel working registers, alignment and pin steering
   // ************************************************************
   pin_t plusPin_q [NCH];
   pin_t minusPin_q[NCH];

   for (genvar ch = 0; ch < NCH; ch++)
   begin : g_ch
      localparam int MATE = ch ^ 1;
      localparam int PAIR = ch / 2;

      logic             odd_q;
      pin_t             plus_d;
      pin_t             minus_d;

      assign enabled[ch]  = (cfg_q[ch].alignMode != ALIGN_OFF) && !periodZero;
      assign dualMode[ch] = (cfg_q[ch].outputMode == OM_DUAL)
                            && (cfg_q[MATE].outputMode == OM_DUAL)
                            && (cfg_q[ch].alignMode != ALIGN_OFF)
                            && (cfg_q[MATE].alignMode != ALIGN_OFF);
      assign load[ch]     = periodZero || (cfg_q[ch].alignMode == ALIGN_OFF)
                            || (overflow && (!dualMode[ch] || oddWritten_q[PAIR]));

      // working duty and sign
      always_ff @(posedge core_clk or negedge rstSyncN_q)
      begin
         if (!rstSyncN_q)
         begin
            workDuty_q[ch] <= DUTY_RST;
            workSign_q[ch] <= 1'b0;
         end
         else if (load[ch])
         begin
            workDuty_q[ch] <= duty_q[ch];
            workSign_q[ch] <= sign_q[ch];
         end
      end

      // period parity cleared only by disable or period zero
      always_ff @(posedge core_clk or negedge rstSyncN_q)
      begin
         if (!rstSyncN_q)
            odd_q <= 1'b0;
         else if (!enabled[ch])
            odd_q <= 1'b0;
         else if (overflow)
            odd_q <= !odd_q;
      end

      wire rightNow = (cfg_q[ch].alignMode == ALIGN_RIGHT)
                      || ((cfg_q[ch].alignMode == ALIGN_CENTER) && odd_q);
      wire leftAct  = (cnt_q < workDuty_q[ch]);
      // right: active from period minus duty
      wire rightAct = (workDuty_q[ch] >= period_q)
                      || ({1'b0, cnt_q} >= ({1'b0, period_q} - {1'b0, workDuty_q[ch]}));
      wire active   = rightNow ? rightAct : leftAct;
      wire actLevel = selectA_q;                   // low for 0, high for 1
      wire pwmLevel = active ? actLevel : !actLevel;
      // pwm on plus when sign differs from select_a
      wire pwmOnP   = workSign_q[ch] ^ selectA_q;
      wire fullMode = cfg_q[ch].outputMode[1];

      // pin steering
      always_comb
      begin
         plus_d  = '{oe: 1'b0, level: 1'b0};
         minus_d = '{oe: 1'b0, level: 1'b0};
         if (enabled[ch] && fullMode)
         begin
            plus_d  = '{oe: 1'b1, level: pwmOnP ? pwmLevel : !actLevel};
            minus_d = '{oe: 1'b1, level: pwmOnP ? !actLevel : pwmLevel};
         end
         else if (enabled[ch] && (cfg_q[ch].outputMode == OM_HALF_P))
            plus_d  = '{oe: 1'b1, level: pwmLevel};
         else if (enabled[ch])
            minus_d = '{oe: 1'b1, level: pwmLevel};
      end

      // registered pins
      always_ff @(posedge core_clk or negedge rstSyncN_q)
      begin
         if (!rstSyncN_q)
         begin
            plusPin_q[ch]  <= '{oe: 1'b0, level: 1'b0};
            minusPin_q[ch] <= '{oe: 1'b0, level: 1'b0};
         end
         else
         begin
            plusPin_q[ch]  <= plus_d;
            minusPin_q[ch] <= minus_d;
         end
      end
   end

   // pin mapping to pairs
   for (genvar p = 0; p < NP; p++)
   begin : g_pair
      assign evenPlusPin[p]  = plusPin_q[2 * p];
      assign evenMinusPin[p] = minusPin_q[2 * p];
      assign oddPlusPin[p]   = plusPin_q[2 * p + 1];
      assign oddMinusPin[p]  = minusPin_q[2 * p + 1];
   end

   // ************************************************************
   // read path
   // ************************************************************
   wire [DATA_W-1:0] dutyView = fast_q
        ? {sign_q[chSel], duty_q[chSel][8:2], 8'h00}
        : {sign_q[chSel], 4'h0, duty_q[chSel]};
   wire [DATA_W-1:0] cfgView  = {7'h00, dualMode[chSel], 4'h0, cfg_q[chSel]};
   wire [DATA_W-1:0] rdMux    = hitCtl   ? {14'h0000, selectA_q, fast_q}
                              : hitPer   ? {5'h00, period_q}
                              : hitCnt   ? {5'h00, cnt_q}
                              : hitChCfg ? cfgView
                              : hitDuty  ? dutyView
                              : 16'h0000;

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk or negedge rstSyncN_q)
   begin
      if (!rstSyncN_q)
         regRdData <= 16'h0000;
      else
         regRdData <= regRd ? rdMux : 16'h0000;
   end

endmodule

// >>> hbridge_pwm_output_steering_properties.sv
// port assertions for the h-bridge pwm output steering block
`timescale 1ns/1ns
module hbridge_pwm_output_steering_properties
#(
   parameter int NP = hbridge_pkg::NUM_PAIRS
)
(
   // clock and reset
   input wire logic                           core_clk,
   input wire logic                           rstn,
   // register port
   input wire logic [hbridge_pkg::ADDR_W-1:0] regAddr,
   input wire logic [hbridge_pkg::DATA_W-1:0] regWrData,
   input wire logic [1:0]                     regWrBytes,
   input wire logic                           regWr,
   input wire logic                           regRd,
   input wire logic [hbridge_pkg::DATA_W-1:0] regRdData,
   // pins
   input wire hbridge_pkg::pin_t [NP-1:0]     evenPlusPin,
   input wire hbridge_pkg::pin_t [NP-1:0]     evenMinusPin,
   input wire hbridge_pkg::pin_t [NP-1:0]     oddPlusPin,
   input wire hbridge_pkg::pin_t [NP-1:0]     oddMinusPin
);
   import hbridge_pkg::*;
   logic [10:0] period_q;
   logic        selA_q;
   logic [1:0]  align0_q;
   wire         bothOe = evenPlusPin[0].oe && evenMinusPin[0].oe;
   // shadow of period, select_a and channel 0 alignment from observed writes
   always_ff @(posedge core_clk or negedge rstn)
      if (!rstn)
      begin
         period_q <= PERIOD_RST;
         selA_q   <= 1'b0;
         align0_q <= 2'h0;
      end
      else if (regWr)
      begin
         if (regAddr == OFS_PERIOD && regWrBytes == 2'h3)
            period_q <= regWrData[10:0];
         if (regAddr == OFS_CONTROL && regWrBytes[0])
            selA_q <= regWrData[CTL_SELA_BIT];
         if (regAddr == 8'h20 && regWrBytes[0])
            align0_q <= regWrData[1:0];
      end
   // ************************************************************
   // properties
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence s_readAt(a); regRd && regAddr == a; endsequence
   sequence s_perZero; (period_q == 11'h000)[*3]; endsequence
   sequence s_off; (align0_q == 2'h0)[*3]; endsequence
   property p_rdIdle; !regRd |=> regRdData == 16'h0000; endproperty
   property p_badAddr; s_readAt(8'hFC) |=> regRdData == 16'h0000; endproperty
   property p_perRead; s_readAt(OFS_PERIOD) |=> regRdData == {5'h00, period_q}; endproperty
   property p_cntRange;
      s_readAt(OFS_COUNTER) ##0 (period_q != 11'h000 && $stable(period_q))
         |=> regRdData < {5'h00, period_q};
   endproperty
   property p_perZero; s_perZero |-> !evenPlusPin[0].oe && !oddMinusPin[0].oe; endproperty
   property p_offRel; s_off |-> !evenPlusPin[0].oe && !evenMinusPin[0].oe; endproperty
   property p_relLevel; !evenMinusPin[0].oe |-> !evenMinusPin[0].level; endproperty
   property p_static;
      $stable(selA_q) && bothOe
         |-> evenPlusPin[0].level == !selA_q || evenMinusPin[0].level == !selA_q;
   endproperty
   property p_rstRel;
      disable iff (1'b0) !rstn |-> !evenPlusPin[0].oe && !evenMinusPin[0].oe
         && !oddPlusPin[0].oe && !oddMinusPin[0].oe;
   endproperty
   a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
   a_badAddr: assert property (p_badAddr) else $error("unmapped read not zero");
   a_perRead: assert property (p_perRead) else $error("period read wrong");
   a_cntRange: assert property (p_cntRange) else $error("counter out of range");
   a_perZero: assert property (p_perZero) else $error("pins driven at period 0");
   a_offRel: assert property (p_offRel) else $error("disabled channel drives");
   a_relLevel: assert property (p_relLevel) else $error("released pin level");
   a_static: assert property (p_static) else $error("no static pin");
   a_rstRel: assert property (p_rstRel) else $error("pins driven in reset");
endmodule
bind hbridge_pwm_output_steering hbridge_pwm_output_steering_properties #(.NP(NP)) props
(
   .core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
   .regWrBytes(regWrBytes), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
   .evenPlusPin(evenPlusPin), .evenMinusPin(evenMinusPin),
   .oddPlusPin(oddPlusPin), .oddMinusPin(oddMinusPin)
);

// >>> hbridge_coil_model.sv
// coil model: wire levels that the coils of pair 0 see
`timescale 1ns/1ns
module hbridge_coil_model
(
   // clock
   input  wire logic                    core_clk,
   // pins: odd minus, odd plus, even minus, even plus
   input  wire hbridge_pkg::pin_t [3:0] pins,
   // resolved wire levels
   output logic [3:0]                   wires
);
   import hbridge_pkg::*;
   logic [3:0] last_q = 4'h0;
   // nobody drives a released wire, so it shows the inverse of its last level
   always_comb
      for (int i = 0; i < 4; i++)
         wires[i] = pins[i].oe ? pins[i].level : ~last_q[i];
   // remember each wire level
   always_ff @(posedge core_clk)
      last_q <= wires;
endmodule

// >>> test_hbridge_pwm_output_steering.sv
// self-checking bench for the h-bridge pwm output steering block
`timescale 1ns/1ns
module test_hbridge_pwm_output_steering;
   import hbridge_pkg::*;
   typedef struct packed
   {
      logic       sel;
      logic       sign;
      logic [1:0] om;
      logic [1:0] al;
      logic [7:0] eM;
      logic [7:0] eP;
      logic       oeM;
      logic       oeP;
   } row_t;
   logic                 core_clk   = 1'b0;
   logic                 rstn       = 1'b1;
   logic [ADDR_W-1:0]    regAddr    = 8'h00;
   logic [DATA_W-1:0]    regWrData  = 16'h0000;
   logic [1:0]           regWrBytes = 2'h0;
   logic                 regWr      = 1'b0;
   logic                 regRd      = 1'b0;
   logic [DATA_W-1:0]    regRdData;
   pin_t [NUM_PAIRS-1:0] ep, em, op, om;
   logic [3:0]           wires;
   logic                 curSel     = 1'b0;
   logic [7:0]           m, p;
   logic [15:0]          v;
   int                   err_count  = 0;
   int                   num_checks = 0;
   row_t                 rows [8];
   // clock
   always #2 core_clk = ~core_clk;
   hbridge_pwm_output_steering #(.NP(NUM_PAIRS)) uut
   (
      .core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
      .regWrBytes(regWrBytes), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .evenPlusPin(ep), .evenMinusPin(em), .oddPlusPin(op), .oddMinusPin(om)
   );
   hbridge_coil_model coil (.core_clk(core_clk), .pins({om[0], op[0], em[0], ep[0]}),
      .wires(wires));
   // ************************************************************
   // tasks
   // ************************************************************
   // register writes with byte enables
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b);
      @(posedge core_clk);
      regWr      <= 1'b1;
      regAddr    <= a;
      regWrData  <= d;
      regWrBytes <= b;
      @(posedge core_clk);
      regWr      <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge core_clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd   <= 1'b0;
      @(negedge core_clk);
      d = regRdData;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      num_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // wait for the active cycle of the reference channel (counter zero)
   task automatic waitRef();
      int n;
      n = 0;
      do
      begin
         @(negedge core_clk);
         n++;
      end
      while (wires[3] !== curSel && n < 24);
      if (wires[3] !== curSel)
         chk("ref wait", 16'h0001, 16'h0000);
   endtask
   // capture eight cycles of channel 0 wires from counter zero
   task automatic look(output logic [7:0] mv, output logic [7:0] pv);
      waitRef();
      for (int i = 0; i < 8; i++)
      begin
         mv[i] = wires[1];
         pv[i] = wires[0];
         @(negedge core_clk);
      end
   endtask
   task automatic end_sim();
      if (err_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // watchdog
   initial
   begin
      #20000;
      err_count++;
      end_sim();
   end
   // main sequence
   initial
   begin
      // fall at time zero so the asynchronous reset sees an edge
      rstn <= 1'b0;
      rows = '{'{1'b0, 1'b0, OM_FULL, ALIGN_LEFT, 8'hEE, 8'hFF, 1'b1, 1'b1},
               '{1'b0, 1'b1, OM_FULL, ALIGN_LEFT, 8'hFF, 8'hEE, 1'b1, 1'b1},
               '{1'b1, 1'b0, OM_FULL, ALIGN_LEFT, 8'h00, 8'h11, 1'b1, 1'b1},
               '{1'b1, 1'b1, OM_FULL, ALIGN_LEFT, 8'h11, 8'h00, 1'b1, 1'b1},
               '{1'b1, 1'b0, OM_HALF_P, ALIGN_RIGHT, 8'h00, 8'h88, 1'b0, 1'b1},
               '{1'b0, 1'b1, OM_HALF_M, ALIGN_LEFT, 8'hEE, 8'h00, 1'b1, 1'b0},
               '{1'b0, 1'b0, OM_FULL, ALIGN_RIGHT, 8'h77, 8'hFF, 1'b1, 1'b1},
               '{1'b0, 1'b0, OM_DUAL, ALIGN_RIGHT, 8'h77, 8'hFF, 1'b1, 1'b1}};
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      for (int k = 0; k < NUM_PAIRS; k++)
         chk("pins oe", 16'h0, {12'h0, om[k].oe, op[k].oe, em[k].oe, ep[k].oe});
      rd(8'h20, v);
      chk("ctrl0", 16'h0, v);
      wr(OFS_PERIOD, 16'h0004, 2'h3);
      wr(8'hFC, 16'hFFFF, 2'h3);
      rd(8'hFC, v);
      chk("unmapped", 16'h0, v);
      wr(8'h24, {12'h0, OM_FULL, ALIGN_LEFT}, 2'h3);
      foreach (rows[i])
      begin
         curSel = rows[i].sel;
         wr(OFS_CONTROL, {14'h0, rows[i].sel, 1'b0}, 2'h3);
         wr(8'h44, {rows[i].sel, 15'h0001}, 2'h3);
         wr(8'h20, {12'h0, rows[i].om, rows[i].al}, 2'h3);
         wr(8'h40, {rows[i].sign, 15'h0001}, 2'h3);
         repeat (12) @(posedge core_clk);
         look(m, p);
         chk("oe", {14'h0, rows[i].oeM, rows[i].oeP}, {14'h0, em[0].oe, ep[0].oe});
         if (rows[i].oeM)
            chk("minus", {8'h0, rows[i].eM}, {8'h0, m});
         if (rows[i].oeP)
            chk("plus", {8'h0, rows[i].eP}, {8'h0, p});
         chk("odd plus", {15'h0, !rows[i].sel}, {15'h0, op[0].level});
      end
      rd(OFS_COUNTER, v);
      chk("counter", 16'h1, {15'h0, v < 16'h0004});
      wr(8'h20, {12'h0, OM_FULL, ALIGN_OFF}, 2'h3);
      waitRef();
      wr(8'h20, {12'h0, OM_FULL, ALIGN_CENTER}, 2'h3);
      look(m, p);
      chk("center", 16'h00E7, {8'h0, m});
      wr(8'h20, {12'h0, OM_DUAL, ALIGN_LEFT}, 2'h3);
      wr(8'h24, {12'h0, OM_DUAL, ALIGN_LEFT}, 2'h3);
      rd(8'h20, v);
      chk("dual flag", 16'h010D, v);
      wr(8'h40, 16'h0003, 2'h3);
      wr(8'h40, 16'h0002, 2'h3);
      repeat (12) @(posedge core_clk);
      look(m, p);
      chk("dual held", 16'h00EE, {8'h0, m});
      wr(8'h44, 16'h0001, 2'h3);
      repeat (12) @(posedge core_clk);
      look(m, p);
      chk("dual copy", 16'h00CC, {8'h0, m});
      rd(8'h40, v);
      chk("duty", 16'h0002, v);
      wr(8'h24, {12'h0, OM_FULL, ALIGN_LEFT}, 2'h3);
      rd(8'h20, v);
      chk("lone dual", 16'h000D, v);
      wr(OFS_CONTROL, 16'h0001, 2'h3);
      wr(8'h40, 16'h0100, 2'h2);
      repeat (12) @(posedge core_clk);
      look(m, p);
      chk("fast duty", 16'h0000, {8'h0, m});
      rd(8'h40, v);
      chk("fast read", 16'h0100, v);
      wr(OFS_PERIOD, 16'h0000, 2'h3);
      repeat (4) @(posedge core_clk);
      chk("period 0 oe", 16'h0, {14'h0, em[0].oe, ep[0].oe});
      rd(OFS_COUNTER, v);
      chk("counter stop", 16'h0, v);
      wr(OFS_PERIOD, 16'h0004, 2'h3);
      @(posedge core_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      for (int k = 0; k < NUM_PAIRS; k++)
         chk("reset oe", 16'h0, {12'h0, om[k].oe, op[k].oe, em[k].oe, ep[k].oe});
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(OFS_PERIOD, v);
      chk("period rst", 16'h0, v);
      end_sim();
   end
endmodule
